//--- sideband_ring_pkg.sv
// Constants, register map and types for the slot sideband isolation and ring control.
package sideband_ring_pkg;

    // ************************************************************
    // Slot geometry
    // ************************************************************
    localparam int unsigned NUM_SLOTS = 4;
    localparam int unsigned SLOT_W    = 2;
    localparam int unsigned PRES_W    = 4;

    // ************************************************************
    // Timing figures
    // ************************************************************
    // Sideband reference clock rate gated onto an enabled slot, in Hz.
    localparam int unsigned REF_CLOCK_HZ = 50_000_000;
    // System clock rate in Hz.
    localparam int unsigned SYS_CLOCK_HZ = 40_000_000;

    // ************************************************************
    // Register map, byte addresses on the bus
    // ************************************************************
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] BUS_MAP_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET  = 8'h08;
    localparam logic [7:0] ROUTE_OFFSET   = 8'h0C;

    // Control register fields.
    localparam int unsigned CTRL_SUPPORTED_BIT = 0;
    localparam int unsigned CTRL_SINGLE_BIT    = 1;
    localparam int unsigned CTRL_MGMT_RST_LSB  = 8;

    // Status register fields.
    localparam int unsigned STAT_PRESENT_LSB = 0;
    localparam int unsigned STAT_AUXMODE_LSB = 4;
    localparam int unsigned STAT_ISO_N_LSB   = 8;
    localparam int unsigned STAT_RSTPIN_LSB  = 12;

    // Reset values.
    localparam logic       SUPPORTED_RESET = 1'b1;
    localparam logic       SINGLE_RESET    = 1'b0;
    localparam logic [3:0] MGMT_RST_RESET  = 4'h0;
    localparam logic [3:0] BUS_MAP_RESET   = 4'h0;
    localparam logic [7:0] ROUTE_RESET     = 8'hE4;   // Every slot loops to itself.
    localparam logic [3:0] IDX_BIT0_STRAP  = 4'hA;    // Slots 1 and 3.
    localparam logic [3:0] IDX_BIT1_STRAP  = 4'hC;    // Slots 2 and 3.

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ROUTE_STABLE = 2'h1,
        ROUTE_RECALC = 2'h2
    } route_state_type;

    typedef struct packed {
        logic            supported;
        logic            single_if;
        logic [3:0]      mgmt_rst;
        logic [3:0]      bus_map;
        logic [3:0]      presence;
        logic            pending;
        logic [7:0]      route;
        route_state_type state;
        logic [3:0]      token_in;
        logic [3:0]      iso_n;
        logic [3:0]      clk_en;
        logic [3:0]      rst_oe;
        logic [3:0]      rst_pin;
        logic [3:0]      idx0;
        logic [3:0]      idx1;
        logic            ack;
        logic [31:0]     rdata;
    } ctrl_state_type;

endpackage : sideband_ring_pkg

//--- sideband_ring_ctrl.sv
// Slot sideband isolation, reference clock gating, arbitration ring routing and straps.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps

// Behaviour
// - Isolate sideband pins unless aux enable and good.
// - Keep isolation until slot reaches powered mode.
// - Reference clock gated off until aux mode.
// - Dedicated active-low isolate output drives isolator.
// - Enabled reference clock is the 50 MHz reference.
// - Single interface or unsupported: loop token to itself.
// - Chain populated cards in order, close ring.
// - Rings never cross sideband bus domains.
// - Unpowered inserted cards stay in the ring.
// - Open-drain active-low management bus reset per slot.
// - Aux mode means aux enable and good both high.
// - Presence code lines decide slot population.
module sideband_ring_ctrl
    import sideband_ring_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [3:0]  AUX_POWER_ENABLE,
    input  wire logic [3:0]  CARD_POWER_GOOD,
    input  wire logic [15:0] PRESENCE_CODE_N,
    input  wire logic [3:0]  ARB_TOKEN_OUT,
    output logic      [3:0]  ARB_TOKEN_IN,
    output logic      [3:0]  SIDEBAND_ISOLATE_N,
    output logic      [3:0]  SIDEBAND_REF_CLOCK_EN,
    output logic      [3:0]  SLOT_INDEX_BIT0,
    output logic      [3:0]  SLOT_INDEX_BIT1,
    input  wire logic [3:0]  MGMT_BUS_RESET_N_I,
    output logic      [3:0]  MGMT_BUS_RESET_N_O,
    output logic      [3:0]  MGMT_BUS_RESET_N_OE
);

    // ************************************************************
    // Ring source search
    // ************************************************************
    // Returns the slot whose token output feeds the given slot's input:
    // the nearest earlier populated slot on the same bus, wrapping round.
    // A lone or empty slot, or a disabled ring, feeds itself.
    // Searching backwards means every populated slot is the source of
    // exactly one slot, so with chaining on each bus forms one closed ring.
    // An empty slot keeps its own loop so that a card inserted later
    // joins with a closed path until the next pass has rerouted it.
    function automatic logic [SLOT_W-1:0] ring_source(
        input int unsigned        slot,
        input logic [3:0]         pop,
        input logic [3:0]         bus,
        input logic               chain_en
    );
        logic [SLOT_W-1:0] src;
        logic              found;
        int unsigned       j;
        src   = SLOT_W'(slot);
        found = 1'b0;
        j     = 0;
        if (chain_en && pop[slot]) begin
            for (int unsigned k = 1; k < NUM_SLOTS; k++) begin
                j = (slot + NUM_SLOTS - k) % NUM_SLOTS;
                // Slots on the other bus are skipped, so the search can
                // never hand a token across bus domains.
                // same bus only
                if (!found && pop[j] && (bus[j] == bus[slot])) begin
                    src   = SLOT_W'(j);
                    found = 1'b1;
                end
            end
        end
        return src;
    endfunction : ring_source

    // ************************************************************
    // State
    // ************************************************************
    // One packed record holds every flip-flop of the block; the next-state
    // copy is filled in one process and registered in another, which keeps
    // the reset values and the update rule side by side.
    ctrl_state_type state_q;
    ctrl_state_type state_d;

    // Combinational helpers, recomputed every cycle and never stored.
    // The bus request is qualified by ack so one cycle is taken only once.
    logic [3:0]  pres_now;
    logic [3:0]  aux_mode;
    logic        bus_req;
    logic        bus_wr;
    logic        chain_en;
    logic [31:0] rd_word;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // All control state is computed here and registered below, so every
    // output port but the tied-low MGMT_BUS_RESET_N_O is a flip-flop and the ring never glitches mid-update.
    always_comb begin
        state_d  = state_q;
        pres_now = '0;
        aux_mode = '0;
        rd_word  = '0;
        bus_req  = WB_CYC_I & WB_STB_I & ~state_q.ack;
        bus_wr   = bus_req & WB_WE_I;
        // Chaining needs sideband support and more than one interface;
        // otherwise every slot loops its token straight back to itself.
        chain_en = state_q.supported & ~state_q.single_if;

        // Per-slot presence, power mode, isolation and clock gating.
        // Isolation follows the combined power condition alone, and clock gating
        // also needs sideband support, so a slot with aux enabled but power good
        // still low stays cut off and no leakage path reaches unpowered silicon.
        for (int unsigned s = 0; s < NUM_SLOTS; s++) begin
            pres_now[s] = ~(&PRESENCE_CODE_N[s*PRES_W +: PRES_W]);
            aux_mode[s] = AUX_POWER_ENABLE[s] & CARD_POWER_GOOD[s];
            state_d.iso_n[s]  = aux_mode[s];
            state_d.clk_en[s] = aux_mode[s] & state_q.supported;
            state_d.rst_oe[s] = state_q.mgmt_rst[s];
            // The token path is chosen from presence only; an inserted card
            // that is still unpowered keeps its place in the ring.
            // token routes ignore power
            state_d.token_in[s] = ARB_TOKEN_OUT[state_q.route[s*SLOT_W +: SLOT_W]];
        end
        // The pin level is sampled back so software can see whether the
        // line is actually low, whoever is pulling it.
        state_d.rst_pin  = MGMT_BUS_RESET_N_I;
        state_d.presence = pres_now;

        // The straps never change; they live in flip-flops only so that
        // every output port but MGMT_BUS_RESET_N_O leaves the block from a register.
        // static slot index
        state_d.idx0 = IDX_BIT0_STRAP;
        state_d.idx1 = IDX_BIT1_STRAP;

        // Register writes; only the byte lanes that hold fields matter.
        // A change to the ring settings only arms a pass; the routes
        // themselves move in the recalculation state, never here.
        if (bus_wr) begin
            unique case (WB_ADR_I)
                CONTROL_OFFSET: begin
                    if (WB_SEL_I[0]) begin
                        state_d.supported = WB_DAT_I[CTRL_SUPPORTED_BIT];
                        state_d.single_if = WB_DAT_I[CTRL_SINGLE_BIT];
                        state_d.pending   = 1'b1;
                    end
                    if (WB_SEL_I[1]) begin
                        state_d.mgmt_rst = WB_DAT_I[CTRL_MGMT_RST_LSB +: 4];
                    end
                end
                BUS_MAP_OFFSET: begin
                    if (WB_SEL_I[0]) begin
                        state_d.bus_map = WB_DAT_I[3:0];
                        state_d.pending = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Ring recalculation: old routes hold until the new set is ready.
        // All slots switch in the same edge, so the ring is never left
        // half rerouted with a token path that leads nowhere.
        unique case (state_q.state)
            ROUTE_STABLE: begin
                // Nothing is recomputed while the inputs stand still, so the
                // routes of untouched slots cannot move on their own.
                // reroute only on change
                if ((pres_now != state_q.presence) || state_q.pending) begin
                    state_d.state = ROUTE_RECALC;
                end
            end
            ROUTE_RECALC: begin
                for (int unsigned s = 0; s < NUM_SLOTS; s++) begin
                    // Sources are taken from the registered presence, which
                    // is the copy that the stable state compared against.
                    // self loop when single
                    state_d.route[s*SLOT_W +: SLOT_W] =
                        ring_source(s, state_q.presence, state_q.bus_map, chain_en);
                end
                state_d.state = ROUTE_STABLE;
                // A ring-settings write landing now still triggers another pass, but
                // a presence change seen in this very cycle only leaves pending as it
                // was: the sample register takes the new value now, so unless a pass
                // was already pending the stable state sees no difference and the ring stays stale.
                if (!bus_wr && (pres_now == state_q.presence)) begin
                    state_d.pending = 1'b0;
                end
            end
            default: begin
                state_d.state = ROUTE_STABLE;
            end
        endcase

        // Read mux; unmapped addresses answer with zero.
        // Status fields are registered copies, so a read shows the state
        // one cycle behind the pins.
        unique case (WB_ADR_I)
            CONTROL_OFFSET: begin
                rd_word[CTRL_SUPPORTED_BIT]     = state_q.supported;
                rd_word[CTRL_SINGLE_BIT]        = state_q.single_if;
                rd_word[CTRL_MGMT_RST_LSB +: 4] = state_q.mgmt_rst;
            end
            BUS_MAP_OFFSET: begin
                rd_word[3:0] = state_q.bus_map;
            end
            STATUS_OFFSET: begin
                rd_word[STAT_PRESENT_LSB +: 4] = state_q.presence;
                rd_word[STAT_AUXMODE_LSB +: 4] = state_q.clk_en;
                rd_word[STAT_ISO_N_LSB +: 4]   = state_q.iso_n;
                rd_word[STAT_RSTPIN_LSB +: 4]  = state_q.rst_pin;
            end
            ROUTE_OFFSET: begin
                rd_word[7:0] = state_q.route;
            end
            default: begin
                rd_word = '0;
            end
        endcase

        // Single-wait-state answer: ack one edge after the request.
        // The data word is captured with ack and then held, so a slow
        // master may read it at any time before its next request.
        state_d.ack = bus_req;
        if (bus_req) begin
            state_d.rdata = rd_word;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Reset leaves every slot isolated, clocks off and each ring closed on itself.
    // A pass is left pending so the routes match the cards present
    // as soon as reset is released.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q.supported <= SUPPORTED_RESET;
            state_q.single_if <= SINGLE_RESET;
            state_q.mgmt_rst  <= MGMT_RST_RESET;
            state_q.bus_map   <= BUS_MAP_RESET;
            state_q.presence  <= 4'h0;
            state_q.pending   <= 1'b1;
            state_q.route     <= ROUTE_RESET;
            state_q.state     <= ROUTE_STABLE;
            state_q.token_in  <= 4'h0;
            state_q.iso_n     <= 4'h0;
            state_q.clk_en    <= 4'h0;
            state_q.rst_oe    <= 4'h0;
            state_q.rst_pin   <= 4'hF;
            state_q.idx0      <= IDX_BIT0_STRAP;
            state_q.idx1      <= IDX_BIT1_STRAP;
            state_q.ack       <= 1'b0;
            state_q.rdata     <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Each output but MGMT_BUS_RESET_N_O is a direct copy of a state flip-flop.
    // This costs a cycle of latency on every path but keeps the pins
    // free of glitches from the decode logic.
    assign WB_DAT_O              = state_q.rdata;
    assign WB_ACK_O              = state_q.ack;
    assign ARB_TOKEN_IN          = state_q.token_in;
    assign SIDEBAND_ISOLATE_N    = state_q.iso_n;
    assign SIDEBAND_REF_CLOCK_EN = state_q.clk_en;
    assign SLOT_INDEX_BIT0       = state_q.idx0;
    assign SLOT_INDEX_BIT1       = state_q.idx1;
    // The reset pin is only ever pulled low; the pull-up provides the high.
    // Driving it high would fight other open-drain drivers on the line,
    // so the enable alone decides whether the slot's devices are held.
    assign MGMT_BUS_RESET_N_O    = 4'h0;
    assign MGMT_BUS_RESET_N_OE   = state_q.rst_oe;

endmodule : sideband_ring_ctrl

//--- card_side_model.sv
// Behavioural card side: power good, arbitration token path and reset pin pull-up.
`timescale 1ns/1ps
module card_side_model (
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    input  wire logic [3:0] aux_en,
    input  wire logic [3:0] hold_off,
    input  wire logic       inject,
    input  wire logic [3:0] inject_val,
    input  wire logic [3:0] token_in,
    input  wire logic [3:0] rst_oe,
    input  wire logic [3:0] idx0,
    input  wire logic [3:0] idx1,
    output logic      [3:0] power_good,
    output logic      [3:0] token_out,
    output logic      [3:0] rst_pin,
    output logic     [11:0] pkg_first,
    output logic     [11:0] pkg_second,
    output logic      [7:0] eeprom_addr
);
    // good after aux
    // Good trails aux by a cycle; hold_off keeps a slot stuck with aux high and good low.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) power_good <= 4'h0;
        else power_good <= aux_en & ~hold_off;
    end
    // token pass-through
    // At rest a card hands its token straight on; inject lets the bench force a pattern.
    assign token_out = inject ? inject_val : token_in;
    assign rst_pin = ~rst_oe;
    // Each card carries two controllers; their package indices see the slot
    // index only once local power is good, while the EEPROM sees it always.
    // index to package bits
    for (genvar s = 0; s < 4; s++) begin : g_card
        assign pkg_first[3*s +: 3]   = {1'b0, power_good[s] ? {idx1[s], idx0[s]} : 2'b00};
        assign pkg_second[3*s +: 3]  = {1'b1, power_good[s] ? {idx1[s], idx0[s]} : 2'b00};
        assign eeprom_addr[2*s +: 2] = {idx1[s], idx0[s]};
    end
endmodule : card_side_model

//--- sideband_ring_chk_sva.sv
// Concurrent checks on the sideband controller ports.
`timescale 1ns/1ps
module sideband_ring_chk (
    input wire logic        SYS_CLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    input wire logic [3:0]  AUX_POWER_ENABLE,
    input wire logic [3:0]  CARD_POWER_GOOD,
    input wire logic [15:0] PRESENCE_CODE_N,
    input wire logic [3:0]  ARB_TOKEN_OUT,
    input wire logic [3:0]  ARB_TOKEN_IN,
    input wire logic [3:0]  SIDEBAND_ISOLATE_N,
    input wire logic [3:0]  SIDEBAND_REF_CLOCK_EN,
    input wire logic [3:0]  SLOT_INDEX_BIT0,
    input wire logic [3:0]  SLOT_INDEX_BIT1,
    input wire logic [3:0]  MGMT_BUS_RESET_N_O
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // The route stability check needs still inputs and no bus traffic, which could start a reroute.
    sequence quiet_s; $stable(ARB_TOKEN_OUT) && $stable(PRESENCE_CODE_N) && !WB_CYC_I; endsequence
    sequence empty_s; PRESENCE_CODE_N == 16'hFFFF; endsequence
    iso_power_a: assert property (!$past(RST) |->
        SIDEBAND_ISOLATE_N == $past(AUX_POWER_ENABLE & CARD_POWER_GOOD))
        else $error("isolate mismatch");
    clk_gate_a: assert property (!$past(RST) |->
        (SIDEBAND_REF_CLOCK_EN & ~$past(AUX_POWER_ENABLE & CARD_POWER_GOOD)) == 4'h0)
        else $error("ref clock early");
    clk_iso_a: assert property ((SIDEBAND_REF_CLOCK_EN & ~SIDEBAND_ISOLATE_N) == 4'h0)
        else $error("clock on isolated slot");
    strap_const_a: assert property (SLOT_INDEX_BIT0 == 4'hA && SLOT_INDEX_BIT1 == 4'hC)
        else $error("slot index wrong");
    od_low_a: assert property (MGMT_BUS_RESET_N_O == 4'h0)
        else $error("reset pin driven high");
    ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack late");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    loop_empty_a: assert property (empty_s [*4] ##0 !$past(RST, 8) |=>
        ARB_TOKEN_IN == $past(ARB_TOKEN_OUT)) else $error("empty ring not self looped");
    route_still_a: assert property (quiet_s [*6] ##0 !$past(RST, 8) |->
        $stable(ARB_TOKEN_IN)) else $error("ring moved while quiet");
endmodule : sideband_ring_chk

bind sideband_ring_ctrl sideband_ring_chk chk_i (
    .SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .AUX_POWER_ENABLE(AUX_POWER_ENABLE), .CARD_POWER_GOOD(CARD_POWER_GOOD),
    .PRESENCE_CODE_N(PRESENCE_CODE_N), .ARB_TOKEN_OUT(ARB_TOKEN_OUT), .ARB_TOKEN_IN(ARB_TOKEN_IN),
    .SIDEBAND_ISOLATE_N(SIDEBAND_ISOLATE_N), .SIDEBAND_REF_CLOCK_EN(SIDEBAND_REF_CLOCK_EN),
    .SLOT_INDEX_BIT0(SLOT_INDEX_BIT0), .SLOT_INDEX_BIT1(SLOT_INDEX_BIT1),
    .MGMT_BUS_RESET_N_O(MGMT_BUS_RESET_N_O)
);

//--- sideband_ring_ctrl_tb.sv
// Self-checking bench for the sideband isolation and ring controller.
`timescale 1ns/1ps
module sideband_ring_ctrl_tb;
    import sideband_ring_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, inj = 1'b1, ack;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] pres = 16'hFFFF;
    logic [3:0]  aux = 4'h0, hold = 4'h0, inj_v = 4'h0;
    logic [3:0]  tok_in, tok_out, iso_n, ref_en, idx0, idx1, pg, pin, rst_oe;
    logic [11:0] pk0, pk1;
    logic [7:0]  ee;
    int          seed = 32'h771d, fail_count = 0, checks_done = 0, tmo = 0;
    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;
    sideband_ring_ctrl dut (
        .SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .AUX_POWER_ENABLE(aux), .CARD_POWER_GOOD(pg), .PRESENCE_CODE_N(pres),
        .ARB_TOKEN_OUT(tok_out), .ARB_TOKEN_IN(tok_in), .SIDEBAND_ISOLATE_N(iso_n),
        .SIDEBAND_REF_CLOCK_EN(ref_en), .SLOT_INDEX_BIT0(idx0), .SLOT_INDEX_BIT1(idx1),
        .MGMT_BUS_RESET_N_I(pin), .MGMT_BUS_RESET_N_O(), .MGMT_BUS_RESET_N_OE(rst_oe));
    card_side_model card (
        .SYS_CLK(clk), .RST(rst), .aux_en(aux), .hold_off(hold), .inject(inj),
        .inject_val(inj_v), .token_in(tok_in), .rst_oe(rst_oe), .power_good(pg),
        .token_out(tok_out), .rst_pin(pin), .idx0(idx0), .idx1(idx1),
        .pkg_first(pk0), .pkg_second(pk1), .eeprom_addr(ee));
    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        tmo++;
        if (tmo == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    // Compare and count; case inequality so unknowns never match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic single Wishbone cycle; ack and data are taken at the rising edge that shows ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    // Source slot feeding slot s: nearest earlier populated slot on the same bus, wrapping round, else itself.
    function automatic int src(int s, logic [3:0] pop, logic [3:0] bm, logic en);
        int j;
        if (!en || !pop[s]) return s;
        for (int k = 1; k < 4; k++) begin
            j = (s + 4 - k) % 4;
            if (pop[j] && bm[j] == bm[s]) return j;
        end
        return s;
    endfunction : src
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Main sequence: reset values, then random power, presence and ring settings.
    initial begin
        int e, v;
        logic [31:0] r, ex;
        logic [11:0] ctl;
        logic [3:0]  pop, bm;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, CONTROL_OFFSET, 32'h0, r);
        chk(r, 32'h1);
        wb(1'b0, ROUTE_OFFSET, 32'h0, r);
        chk(r, 32'hE4);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF, r);
        wb(1'b0, 8'h10, 32'h0, r);
        chk(r, 32'h0);
        wb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF, r);
        wb(1'b0, STATUS_OFFSET, 32'h0, r);
        chk(r, 32'hF000);
        chk({24'h0, idx1, idx0}, 32'hCA);
        $display("register test done");
        for (int i = 0; i < 16; i++) begin
            ctl = 12'($random(seed));
            bm = 4'($random(seed));
            pop = 4'($random(seed));
            wb(1'b1, CONTROL_OFFSET, {20'h0, ctl[11:8], 6'h0, ctl[1:0]}, r);
            wb(1'b1, BUS_MAP_OFFSET, {28'h0, bm}, r);
            @(posedge clk);
            for (int s = 0; s < 4; s++) begin
                v = $random(seed);
                pres[4*s +: 4] <= pop[s] ? (v[3:0] & ~(4'h1 << v[5:4])) : 4'hF;
            end
            aux <= 4'($random(seed));
            hold <= 4'($random(seed));
            inj_v <= 4'($random(seed));
            repeat (5) @(negedge clk);
            ex = 32'h0;
            v = 0;
            for (int s = 0; s < 4; s++) begin
                e = src(s, pop, bm, ctl[0] & ~ctl[1]);
                ex[2*s +: 2] = e[1:0];
                v[s] = inj_v[e];
            end
            e = aux & ~hold;
            chk(iso_n, e[3:0]);
            chk(ref_en, ctl[0] ? e[3:0] : 4'h0);
            chk(rst_oe, ctl[11:8]);
            chk(tok_in, v[3:0]);
            wb(1'b0, ROUTE_OFFSET, 32'h0, r);
            chk(r, ex);
            wb(1'b0, STATUS_OFFSET, 32'h0, r);
            chk(r, {16'h0, ~ctl[11:8], e[3:0], ctl[0] ? e[3:0] : 4'h0, pop});
            for (int s = 0; s < 4; s++) begin
                v = e[s] ? s : 0;
                chk(pk0[3*s +: 3], v);
                chk(pk1[3*s +: 3], 4 + v);
                if (e[s]) chk(pk0[3*s +: 2], s);
                chk(ee[2*s +: 2], s);
            end
        end
        $display("power and ring test done");
        @(posedge clk);
        pres <= 16'hFFFF;
        repeat (6) @(posedge clk);
        inj <= 1'b0;
        repeat (12) @(negedge clk);
        chk(tok_in, inj_v);
        $display("empty ring test done");
        finish_test();
    end
endmodule : sideband_ring_ctrl_tb
